// ==== inc/rac_pkg.sv ====
// Purpose: shared constants and carriers for the register access conventions block
// Assumes: 8-bit registers, one system clock at 50 MHz
// Notes: map and reset values are a small example register bank
package rac_pkg;

    localparam int RAC_DW = 8;
    localparam int RAC_AW = 3;

    // register offsets
    localparam logic [2:0] RAC_OFS_CTRL = 3'h0;  // read-write with a reserved field
    localparam logic [2:0] RAC_OFS_STATUS = 3'h1;  // read-only
    localparam logic [2:0] RAC_OFS_CMD = 3'h2;  // write-only
    localparam logic [2:0] RAC_OFS_OUT = 3'h3;  // shared value, plain view
    localparam logic [2:0] RAC_OFS_OUT_SET = 3'h4;
    localparam logic [2:0] RAC_OFS_OUT_CLR = 3'h5;  // clear_alias_register
    localparam logic [2:0] RAC_OFS_DBGCTRL = 3'h6;  // debug control, kept on soft reset

    // implemented-bit masks; zeros are reserved positions
    localparam logic [7:0] RAC_MASK_CTRL = 8'h3f;
    localparam logic [7:0] RAC_MASK_CMD = 8'h03;
    localparam logic [7:0] RAC_MASK_DBG = 8'h01;

    // ctrl field layout: mode in [5:4], enable in [0]
    localparam int RAC_CTRL_MODE_LSB = 4;
    localparam int RAC_CTRL_EN_BIT = 0;
    localparam logic [1:0] RAC_MODE_RSVD = 2'h3;  // reserved encoding

    // cmd field layout: soft reset bit
    localparam int RAC_CMD_SWRST_BIT = 0;

    // reset values
    localparam logic [7:0] RAC_RST_CTRL = 8'h00;
    localparam logic [7:0] RAC_RST_OUT = 8'h00;
    localparam logic [7:0] RAC_RST_DBG = 8'h00;
    localparam logic [7:0] RAC_RST_CMD = 8'h00;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } rac_req_s;

endpackage : rac_pkg

// ==== hdl/rac_setclr.sv ====
// Purpose: one register shared by a set alias and a clear alias
// Assumes: synchronous reset, both aliases may be written in one cycle
// Notes: clear wins over set for a bit written one through both
`timescale 1ns/1ps
module rac_setclr (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic soft_rst_i,
    input wire logic wr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic set_i,
    input wire logic clr_i,
    input wire logic [7:0] set_mask_i,
    input wire logic [7:0] clr_mask_i,
    output logic [7:0] value_o
);
    import rac_pkg::*;

    logic [7:0] set_bits;
    logic [7:0] clr_bits;
    logic [7:0] next_value;

    // zeros through either alias leave bits alone; clear applied last wins
    // each alias carries its own data, so a same-cycle pair keeps both masks
    assign set_bits = set_i ? set_mask_i : 8'h00; // RULE_08 RULE_12
    assign clr_bits = clr_i ? clr_mask_i : 8'h00; // RULE_07 RULE_12
    assign next_value = ((wr_i ? wr_data_i : value_o) | set_bits) & ~clr_bits; // RULE_10

    // one register, so both aliases always see the same value
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || soft_rst_i) begin
            value_o <= RAC_RST_OUT; // RULE_11
        end else begin
            value_o <= next_value;
        end
    end

endmodule : rac_setclr

// ==== hdl/rac_regbank.sv ====
// Purpose: example register bank keeping the common access conventions
// Assumes: one-cycle read latency, requests synchronous to clk_sys_i
// Notes: reserved bits drop on write and read as zero
`timescale 1ns/1ps

// Behaviour
// RULE_01 - read-write bits return last written value and accept writes
// RULE_02 - read-only bits ignore every software write
// RULE_03 - write-only bits accept writes; reads return an undefined value
// RULE_04 - reserved bit positions always read back as zero
// RULE_05 - software writes zero into reserved bit positions
// RULE_06 - no reserved encoding written by software or shown by read-only field
// RULE_07 - one written to clear alias clears shared bit in both views
// RULE_08 - one written to set alias sets shared bit in both views
// RULE_09 - both aliases read the same current value
// RULE_10 - simultaneous set and clear of a bit: clear wins
// RULE_11 - power reset loads reset values; soft reset too, except debug control
// RULE_12 - zeros written through either alias leave bits unchanged
module rac_regbank (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire rac_pkg::rac_req_s req_i,
    input wire logic set_wr_i,
    input wire logic [7:0] set_data_i,
    input wire logic [7:0] status_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic [7:0] ctrl_o,
    output logic [7:0] out_o,
    output logic [7:0] dbg_o,
    output logic cmd_pulse_o
);
    import rac_pkg::*;

    logic [7:0] ctrl;
    logic [7:0] dbg;
    logic [7:0] status;
    logic soft_rst;
    logic [7:0] out_value;
    logic [7:0] next_ctrl;
    logic [7:0] read_mux;
    logic [1:0] wr_mode;
    logic [1:0] status_mode;
    logic wr_ctrl;
    logic wr_dbg;
    logic wr_cmd;
    logic wr_out;
    logic wr_clr;
    logic wr_set;
    logic any_set;
    logic [7:0] side_set_mask;
    logic [7:0] bus_set_mask;
    logic [7:0] set_mask;
    logic [7:0] clr_mask;

    // map of this bank, one byte per offset:
    //   0 control, read-write, mode field, enable bit and plain bits 3:1, bits 7:6 reserved
    //   1 status, read-only view of a live source
    //   2 command, write-only, bit 0 starts a soft reset
    //   3 shared output value, plain read-write view
    //   4 set alias of the shared value
    //   5 clear alias of the shared value
    //   6 debug control, one implemented bit, kept over soft reset
    //   7 unmapped, reads zero and drops writes
    // hazards kept in mind:
    //   reserved bits are masked on the way in, and for debug control also on the way out,
    //   so a stray one in the write data can never be seen again
    //   the alias pair shares a single flop set, so the two views
    //   cannot drift apart even for one cycle
    //   a side-port set strobe may meet a bus clear in the same cycle;
    //   the clear is applied last so it takes precedence
    //   write-only reads give zero here, but software must not rely on it

    // write strobe for one offset; shared by every decode below
    function automatic logic addr_hit(input rac_req_s req, input logic [2:0] ofs);
        logic hit;
        hit = req.wr && (req.addr == ofs);
        return hit;
    endfunction : addr_hit

    // address decode
    assign wr_ctrl = addr_hit(req_i, RAC_OFS_CTRL);
    assign wr_dbg = addr_hit(req_i, RAC_OFS_DBGCTRL);
    assign wr_cmd = addr_hit(req_i, RAC_OFS_CMD);
    assign wr_out = addr_hit(req_i, RAC_OFS_OUT);
    assign wr_clr = addr_hit(req_i, RAC_OFS_OUT_CLR);
    assign wr_set = addr_hit(req_i, RAC_OFS_OUT_SET);
    // set alias may arrive on the side port in the same cycle as a clear write
    assign any_set = set_wr_i || wr_set;

    // alias masks: ones in the data select bits, zeros leave them alone
    assign side_set_mask = set_wr_i ? set_data_i : 8'h00; // RULE_08
    assign bus_set_mask = wr_set ? req_i.wdata : 8'h00; // RULE_08
    assign set_mask = side_set_mask | bus_set_mask; // RULE_12
    assign clr_mask = wr_clr ? req_i.wdata : 8'h00; // RULE_07

    // a reserved mode encoding is refused; the field keeps its old value
    assign wr_mode = req_i.wdata[RAC_CTRL_MODE_LSB +: 2];
    assign next_ctrl = (wr_mode == RAC_MODE_RSVD)
        ? ((req_i.wdata & RAC_MASK_CTRL & ~8'h30) | (ctrl & 8'h30)) // RULE_06
        : (req_i.wdata & RAC_MASK_CTRL); // RULE_01 RULE_04

    // soft reset is a self-clearing write-only command bit
    assign soft_rst = wr_cmd && req_i.wdata[RAC_CMD_SWRST_BIT]; // RULE_03

    // read-only status: never shows the reserved mode encoding
    assign status_mode = (status_i[5:4] == RAC_MODE_RSVD) ? 2'h0 : status_i[5:4]; // RULE_06
    assign status = {status_i[7:6], status_mode, status_i[3:0]}; // RULE_02

    // read mux: set and clear aliases both show the shared value
    always_comb begin
        unique case (req_i.addr)
            RAC_OFS_CTRL: read_mux = ctrl;
            RAC_OFS_STATUS: read_mux = status;
            RAC_OFS_CMD: read_mux = 8'h00; // RULE_03
            RAC_OFS_OUT, RAC_OFS_OUT_SET, RAC_OFS_OUT_CLR: read_mux = out_value; // RULE_09
            RAC_OFS_DBGCTRL: read_mux = dbg & RAC_MASK_DBG; // RULE_04
            default: read_mux = 8'h00; // RULE_04
        endcase
    end

    // shared set/clear register
    rac_setclr u_out (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .soft_rst_i(soft_rst),
        .wr_i(wr_out),
        .wr_data_i(req_i.wdata),
        .set_i(any_set),
        .clr_i(wr_clr),
        .set_mask_i(set_mask),
        .clr_mask_i(clr_mask),
        .value_o(out_value)
    );

    // control register: soft reset restores it
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || soft_rst) begin
            ctrl <= RAC_RST_CTRL; // RULE_11
        end else if (wr_ctrl) begin
            ctrl <= next_ctrl; // RULE_01
        end
    end

    // debug control survives a soft reset, only power reset clears it
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            dbg <= RAC_RST_DBG; // RULE_11
        end else if (wr_dbg) begin
            dbg <= req_i.wdata & RAC_MASK_DBG; // RULE_04
        end
    end

    // registered read data and outputs
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
            cmd_pulse_o <= 1'b0;
        end else begin
            rdata_o <= req_i.rd ? read_mux : 8'h00;
            rvalid_o <= req_i.rd;
            cmd_pulse_o <= soft_rst;
        end
    end

    // mirrored outputs from flip-flops
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ctrl_o <= RAC_RST_CTRL;
            out_o <= RAC_RST_OUT;
            dbg_o <= RAC_RST_DBG;
        end else begin
            ctrl_o <= ctrl;
            out_o <= out_value;
            dbg_o <= dbg;
        end
    end

endmodule : rac_regbank

// ==== dv/rac_regbank_asserts.sv ====
// Purpose: port-level checks of the register bank
// Assumes: one clock, sync reset, mirrors one cycle behind the registers
// Notes: status field is compared only when its live mode is legal
`timescale 1ns/1ps
module rac_regbank_asserts (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire rac_pkg::rac_req_s req_i,
    input wire logic set_wr_i,
    input wire logic [7:0] status_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic [7:0] ctrl_o,
    input wire logic [7:0] out_o,
    input wire logic [7:0] dbg_o,
    input wire logic cmd_pulse_o
);
    import rac_pkg::*;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // soft reset: pulse first, then the ctrl and out mirrors show reset values while the dbg mirror holds
    sequence soft_cmd;
        req_i.wr && req_i.addr == RAC_OFS_CMD && req_i.wdata[RAC_CMD_SWRST_BIT];
    endsequence
    sequence back_to_reset;
        cmd_pulse_o ##1 (ctrl_o == RAC_RST_CTRL && out_o == RAC_RST_OUT && $stable(dbg_o));
    endsequence
    rvalid_follow_a: assert property (rvalid_o == $past(req_i.rd))
        else $error("read valid out of step");
    ctrl_readback_a: assert property (req_i.wr && req_i.addr == RAC_OFS_CTRL &&
        req_i.wdata[5:4] != RAC_MODE_RSVD |-> ##2 ctrl_o == ($past(req_i.wdata, 2) & RAC_MASK_CTRL))
        else $error("ctrl readback wrong");
    status_ro_a: assert property (req_i.rd && req_i.addr == RAC_OFS_STATUS &&
        status_i[5:4] != RAC_MODE_RSVD |=> rdata_o == $past(status_i)) else $error("status wrong");
    rsvd_zero_a: assert property ((ctrl_o & ~RAC_MASK_CTRL) == 8'h00 &&
        (dbg_o & ~RAC_MASK_DBG) == 8'h00) else $error("reserved bit set");
    mode_legal_a: assert property (ctrl_o[5:4] != RAC_MODE_RSVD && !(rvalid_o &&
        $past(req_i.addr) == RAC_OFS_STATUS && rdata_o[5:4] == RAC_MODE_RSVD))
        else $error("reserved mode shown");
    clear_wins_a: assert property (req_i.wr && req_i.addr == RAC_OFS_OUT_CLR |->
        ##2 (out_o & $past(req_i.wdata, 2)) == 8'h00) else $error("clear alias failed");
    set_bits_a: assert property (req_i.wr && req_i.addr == RAC_OFS_OUT_SET |->
        ##2 (out_o & $past(req_i.wdata, 2)) == $past(req_i.wdata, 2)) else $error("set failed");
    zero_keep_a: assert property (req_i.wr && req_i.addr == RAC_OFS_OUT_SET && !set_wr_i |-> ##2
        (out_o & ~$past(req_i.wdata, 2)) == ($past(out_o) & ~$past(req_i.wdata, 2)))
        else $error("zero bit changed");
    soft_reset_a: assert property (soft_cmd |=> back_to_reset)
        else $error("soft reset wrong");
endmodule : rac_regbank_asserts

// ==== dv/test_register_access_conventions.sv ====
// Purpose: directed bench for the register bank
// Assumes: one request then one idle edge per access
// Notes: write-only reads are never compared, their value is undefined
`timescale 1ns/1ps
module test_register_access_conventions;
    import rac_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    rac_req_s req_i = '0;
    logic set_wr_i = 1'b0;
    logic [7:0] set_data_i = 8'h00;
    logic [7:0] status_i = 8'h00;
    logic [7:0] rdata_o, ctrl_o, out_o, dbg_o;
    logic rvalid_o, cmd_pulse_o;
    int n_fail = 0;
    int tests_run = 0;
    rac_regbank rac_regbank_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
        .set_wr_i(set_wr_i), .set_data_i(set_data_i), .status_i(status_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .ctrl_o(ctrl_o), .out_o(out_o), .dbg_o(dbg_o),
        .cmd_pulse_o(cmd_pulse_o));
    // 50 MHz clock
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one request edge, then idle; read data has landed 1 ns after the idle edge
    task automatic op(input logic [2:0] a, input logic [7:0] d, input logic r, input logic s,
        input logic [7:0] sd);
        @(posedge clk_sys_i);
        req_i <= '{wr: !r, rd: r, addr: a, wdata: d};
        set_wr_i <= s;
        set_data_i <= sd;
        @(posedge clk_sys_i);
        req_i <= '0;
        set_wr_i <= 1'b0;
        #1;
    endtask : op
    task automatic w(input logic [2:0] a, input logic [7:0] d);
        op(a, d, 1'b0, 1'b0, 8'h00);
    endtask : w
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        op(a, 8'h00, 1'b1, 1'b0, 8'h00);
        chk($sformatf("reg %0d", a), rdata_o, e);
        chk("rvalid", {7'h00, rvalid_o}, 8'h01);
    endtask : rd
    task automatic t_rw();
        w(RAC_OFS_CTRL, 8'h25);
        rd(RAC_OFS_CTRL, 8'h25);
        w(RAC_OFS_CTRL, 8'h05);
        rd(RAC_OFS_CTRL, 8'h05);
        w(RAC_OFS_CTRL, 8'h11);
        rd(RAC_OFS_CTRL, 8'h11);
        w(RAC_OFS_CMD, 8'h02);
        rd(RAC_OFS_CTRL, 8'h11);
        rd(3'h7, 8'h00);
        chk("ctrl mirror", ctrl_o, 8'h11);
    endtask : t_rw
    task automatic t_ro();
        @(posedge clk_sys_i);
        status_i <= 8'h12;
        w(RAC_OFS_STATUS, 8'hff);
        rd(RAC_OFS_STATUS, 8'h12);
        status_i <= 8'h3c;
        rd(RAC_OFS_STATUS, 8'h0c);
    endtask : t_ro
    task automatic t_alias();
        w(RAC_OFS_OUT, 8'h0f);
        w(RAC_OFS_OUT_SET, 8'h30);
        rd(RAC_OFS_OUT_SET, 8'h3f);
        rd(RAC_OFS_OUT_CLR, 8'h3f);
        w(RAC_OFS_OUT_CLR, 8'h05);
        rd(RAC_OFS_OUT, 8'h3a);
        op(RAC_OFS_OUT_CLR, 8'h81, 1'b0, 1'b1, 8'hc1);
        rd(RAC_OFS_OUT_SET, 8'h7a);
        chk("out mirror", out_o, 8'h7a);
    endtask : t_alias
    task automatic t_soft();
        w(RAC_OFS_DBGCTRL, 8'h01);
        w(RAC_OFS_CMD, 8'h01);
        chk("soft pulse", {7'h00, cmd_pulse_o}, 8'h01);
        rd(RAC_OFS_CTRL, RAC_RST_CTRL);
        rd(RAC_OFS_OUT, RAC_RST_OUT);
        rd(RAC_OFS_DBGCTRL, 8'h01);
        chk("dbg mirror", dbg_o, 8'h01);
    endtask : t_soft
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    // a full run takes about 1.3 us; a hang is cut off well after that
    initial begin
        #50us;
        n_fail++;
        wrap_up();
    end
    // main sequence, power reset checked again at the end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        t_rw();
        t_ro();
        t_alias();
        t_soft();
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b1;
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rd(RAC_OFS_DBGCTRL, RAC_RST_DBG);
        wrap_up();
    end
endmodule : test_register_access_conventions
bind rac_regbank rac_regbank_asserts rac_regbank_asserts_inst (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .req_i(req_i), .set_wr_i(set_wr_i), .status_i(status_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .ctrl_o(ctrl_o), .out_o(out_o), .dbg_o(dbg_o),
    .cmd_pulse_o(cmd_pulse_o));
